// File: hw/ulm_pkg.sv
// Contract
// - receive trigger from fifo_control bits 7:6: 1, 4, 8 or 14 characters.
// - receive data interrupt when receive fifo count reaches the trigger level.
// - transmit trigger from fifo_control bits 5:4 when enhanced: 4, 8 or 14; 0 leaves bits 7:6 in charge.
// - one shared trigger selection; the latest written selection governs both directions.
// - line_format_control bits 1:0 pick 5, 6, 7 or 8 data bits.
// - bit 2 gives 1.5 stop bits for 5-bit characters, else two.
// - parity enable adds a transmit parity bit and checks receive parity.
// - unforced parity is odd when even-select is 0, even when 1.
// - forced parity is 1 when even-select is 0, 0 when 1.
// - break bit holds the serial output low, outside loopback, until software clears it.
// - bit 7 steers shared addresses to the baud divisor latches.
// - modem_output_control bit 0 drives terminal-ready output low when set, outside loopback.
// - bit 1 drives request-to-send output low when set, outside loopback.
// - bit 4 enables loopback; bit 2 supplies the internal ring indicator.
// - bit 3 enables the interrupt pin driver, and drives user_output_two inversely.
// - xon-any lets any received character except an XOFF under software flow control resume a halted transmitter.
// - infrared mode encodes and decodes the line; idle encoded output is low.
// - prescaler bit divides the input clock by four before the baud divider.
// - overrun interrupts at once; parity error when its character is at the head.
// - data-ready status is set while any received character is held.
// - full receive fifo flags overrun and keeps the new character out.
// - parity error status follows the character at the receive head.
// - transmit interrupt while transmit fifo count is below the trigger level.
package ulm_pkg;
  localparam logic [7:0] ULM_A_DATA = 8'h00;
  localparam logic [7:0] ULM_A_IER = 8'h04;
  localparam logic [7:0] ULM_A_FIFO = 8'h08;
  localparam logic [7:0] ULM_A_LCR = 8'h0c;
  localparam logic [7:0] ULM_A_MCR = 8'h10;
  localparam logic [7:0] ULM_A_LSR = 8'h14;
  localparam logic [7:0] ULM_A_EFR = 8'h18;
  localparam logic [7:0] ULM_A_LOOP = 8'h1c;
  localparam int ULM_FC_EN = 0;
  localparam int ULM_FC_RXRST = 1;
  localparam int ULM_FC_TXRST = 2;
  localparam int ULM_LCR_STOP = 2;
  localparam int ULM_LCR_PEN = 3;
  localparam int ULM_LCR_EVEN = 4;
  localparam int ULM_LCR_FORCE = 5;
  localparam int ULM_LCR_BRK = 6;
  localparam int ULM_LCR_DLAB = 7;
  localparam int ULM_MCR_DTR = 0;
  localparam int ULM_MCR_RTS = 1;
  localparam int ULM_MCR_OP1 = 2;
  localparam int ULM_MCR_INTEN = 3;
  localparam int ULM_MCR_LOOP = 4;
  localparam int ULM_MCR_XANY = 5;
  localparam int ULM_MCR_IR = 6;
  localparam int ULM_MCR_PRE = 7;
  localparam int ULM_IER_RX = 0;
  localparam int ULM_IER_TX = 1;
  localparam int ULM_IER_LS = 2;
  localparam int ULM_EFR_SWFC = 3;
  localparam int ULM_EFR_ENH = 4;
  localparam logic [4:0] ULM_TRIG0 = 5'h01;
  localparam logic [4:0] ULM_TRIG1 = 5'h04;
  localparam logic [4:0] ULM_TRIG2 = 5'h08;
  localparam logic [4:0] ULM_TRIG3 = 5'h0e;
  localparam logic [3:0] ULM_ISR_LS = 4'h6;
  localparam logic [3:0] ULM_ISR_RX = 4'h4;
  localparam logic [3:0] ULM_ISR_TX = 4'h2;
  localparam logic [3:0] ULM_ISR_NONE = 4'h1;
  localparam logic [7:0] ULM_XON = 8'h11;
  localparam logic [7:0] ULM_XOFF = 8'h13;
  localparam int ULM_DEPTH = 16;
  localparam int ULM_OSR = 16;
  localparam int ULM_MID = 8;
  localparam int ULM_IR_PULSE = 3;
  localparam int ULM_PRE_DIV = 4;
  typedef enum logic [2:0] {ULM_IDLE, ULM_START, ULM_DATA, ULM_PAR, ULM_STOP} ulm_ph_t;
endpackage

// File: hw/ulm_uart.sv
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module ulm_uart #(
  parameter int DEPTH = ulm_pkg::ULM_DEPTH,
  parameter int OSR = ulm_pkg::ULM_OSR
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // serial line and modem outputs
  input wire logic rx_i,
  output logic tx_o,
  output logic dtr_n_o,
  output logic rts_n_o,
  // interrupt pin
  output logic int_o,
  output logic int_oe_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [7:0] ier;
    logic [7:0] line_format_control;
    logic [7:0] modem_output_control;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] dll;
    logic [7:0] dlm;
    logic [1:0] trig;
    logic fifo_en;
    logic [1:0] pre;
    logic [15:0] bcnt;
    ulm_pkg::ulm_ph_t tx_st;
    logic [7:0] tx_sh;
    logic [5:0] tx_tk;
    logic [2:0] tx_bit;
    logic tx_line;
    logic tx_par;
    ulm_pkg::ulm_ph_t rx_st;
    logic [7:0] rx_sh;
    logic [5:0] rx_tk;
    logic [2:0] rx_bit;
    logic rx_par;
    logic rx_pe;
    logic [DEPTH-1:0][7:0] txf;
    logic [AW-1:0] tx_wp;
    logic [AW-1:0] tx_rp;
    logic [CW-1:0] tx_cnt;
    logic [DEPTH-1:0][8:0] rxf;
    logic [AW-1:0] rx_wp;
    logic [AW-1:0] rx_rp;
    logic [CW-1:0] rx_cnt;
    logic ovr;
    logic halt;
    logic [5:0] ir_hold;
    logic s1;
    logic s2;
    logic s3;
    logic rxd;
    logic [31:0] rdata;
  } ulm_st_t;

  ulm_st_t s;
  ulm_st_t n;
  logic acc, wr, rd, dlab, enh, loop, ir, brk, swfc, tick, pre_ok, dr;
  logic mapped, lsr_rd, rxrst, txrst, ovr_set, rx_push, rx_pop, tx_push, tx_pop, char_done;
  logic rx_in, ir_tx, lsr_int, rx_int, tx_int;
  logic [2:0] wl;
  logic [5:0] tx_last;
  logic [7:0] rx_char;
  logic [7:0] line_status;
  logic [8:0] head;
  logic [15:0] div;
  logic [CW-1:0] trig_lvl;
  logic [31:0] rmux;

  function automatic logic par_bit(input logic [7:0] line_format_control, input logic x);
    if (line_format_control[ulm_pkg::ULM_LCR_FORCE]) begin
      par_bit = ~line_format_control[ulm_pkg::ULM_LCR_EVEN];
    end else begin
      par_bit = line_format_control[ulm_pkg::ULM_LCR_EVEN] ? x : ~x;
    end
  endfunction

  function automatic logic [CW-1:0] trig_of(input logic [1:0] sel);
    case (sel)
      2'h0: trig_of = CW'(ulm_pkg::ULM_TRIG0);
      2'h1: trig_of = CW'(ulm_pkg::ULM_TRIG1);
      2'h2: trig_of = CW'(ulm_pkg::ULM_TRIG2);
      default: trig_of = CW'(ulm_pkg::ULM_TRIG3);
    endcase
  endfunction

  assign acc = psel_i & penable_i & ce_i;
  assign wr = acc & pwrite_i;
  assign rd = acc & ~pwrite_i;
  assign dlab = s.line_format_control[ulm_pkg::ULM_LCR_DLAB];
  assign enh = s.enhanced_feature_reg[ulm_pkg::ULM_EFR_ENH];
  assign loop = s.modem_output_control[ulm_pkg::ULM_MCR_LOOP];
  assign ir = s.modem_output_control[ulm_pkg::ULM_MCR_IR];
  assign brk = s.line_format_control[ulm_pkg::ULM_LCR_BRK];
  assign swfc = enh & s.enhanced_feature_reg[ulm_pkg::ULM_EFR_SWFC];
  assign div = {s.dlm, s.dll};
  assign pre_ok = ~s.modem_output_control[ulm_pkg::ULM_MCR_PRE] | (s.pre == 2'(ulm_pkg::ULM_PRE_DIV - 1));
  assign tick = pre_ok & (s.bcnt == 16'h0000);
  assign wl = 3'h4 + {1'b0, s.line_format_control[1:0]};
  assign tx_last = (s.tx_st != ulm_pkg::ULM_STOP || !s.line_format_control[ulm_pkg::ULM_LCR_STOP]) ? 6'(OSR - 1) :
                   (s.line_format_control[1:0] == 2'h0) ? 6'(OSR + OSR / 2 - 1) : 6'(2 * OSR - 1);
  assign rx_char = s.rx_sh >> (3'h7 - wl);
  assign head = s.rxf[s.rx_rp];
  assign dr = (s.rx_cnt != '0);
  assign line_status = {1'b0, (s.tx_cnt == '0) && (s.tx_st == ulm_pkg::ULM_IDLE), s.tx_cnt == '0, 2'h0,
                head[8] & dr, s.ovr, dr};
  assign trig_lvl = trig_of(s.trig);
  assign rx_in = loop ? (s.tx_line & ~brk) : ir ? (s.ir_hold == 6'h00) : s.rxd;
  assign ir_tx = (s.tx_st != ulm_pkg::ULM_IDLE) & ~s.tx_line & (s.tx_tk < 6'(ulm_pkg::ULM_IR_PULSE));
  assign lsr_int = s.ier[ulm_pkg::ULM_IER_LS] & (s.ovr | (head[8] & dr));
  assign rx_int = s.ier[ulm_pkg::ULM_IER_RX] & (s.rx_cnt >= trig_lvl);
  assign tx_int = s.ier[ulm_pkg::ULM_IER_TX] & (s.tx_cnt < trig_lvl);

  // outputs
  assign pready_o = ce_i;
  assign pslverr_o = acc & ~mapped;
  assign prdata_o = s.rdata;
  assign tx_o = loop | (~brk & (ir ? ir_tx : s.tx_line));
  assign dtr_n_o = loop | ~s.modem_output_control[ulm_pkg::ULM_MCR_DTR];
  assign rts_n_o = loop | ~s.modem_output_control[ulm_pkg::ULM_MCR_RTS];
  assign int_o = lsr_int | rx_int | tx_int;
  assign int_oe_o = s.modem_output_control[ulm_pkg::ULM_MCR_INTEN];

  always_comb begin
    n = s;
    ovr_set = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    char_done = 1'b0;
    lsr_rd = 1'b0;
    rxrst = 1'b0;
    txrst = 1'b0;
    mapped = 1'b1;
    rmux = 32'h0000_0000;
    // read mux and decode
    case (paddr_i)
      ulm_pkg::ULM_A_DATA: rmux[7:0] = dlab ? s.dll : head[7:0];
      ulm_pkg::ULM_A_IER: rmux[7:0] = dlab ? s.dlm : s.ier;
      ulm_pkg::ULM_A_FIFO: begin
        rmux[7:0] = {s.fifo_en, s.fifo_en, 2'h0, lsr_int ? ulm_pkg::ULM_ISR_LS : rx_int ? ulm_pkg::ULM_ISR_RX :
                     tx_int ? ulm_pkg::ULM_ISR_TX : ulm_pkg::ULM_ISR_NONE};
      end
      ulm_pkg::ULM_A_LCR: rmux[7:0] = s.line_format_control;
      ulm_pkg::ULM_A_MCR: rmux[7:0] = s.modem_output_control;
      ulm_pkg::ULM_A_LSR: rmux[7:0] = line_status;
      ulm_pkg::ULM_A_EFR: rmux[7:0] = s.enhanced_feature_reg;
      ulm_pkg::ULM_A_LOOP: rmux[1:0] = {~s.modem_output_control[ulm_pkg::ULM_MCR_INTEN], loop & s.modem_output_control[ulm_pkg::ULM_MCR_OP1]};
      default: mapped = 1'b0;
    endcase
    if (psel_i && !penable_i) begin
      n.rdata = rmux;
    end
    // input synchroniser and filter
    n.s1 = rx_i;
    n.s2 = s.s1;
    n.s3 = s.s2;
    if (s.s2 == s.s3) begin
      n.rxd = s.s3;
    end
    // infrared pulse decoder
    if (s.rxd) begin
      n.ir_hold = 6'(OSR);
    end else if (tick && s.ir_hold != 6'h00) begin
      n.ir_hold = s.ir_hold - 6'h01;
    end
    // prescaler and baud divider
    n.pre = s.pre + 2'h1;
    if (pre_ok) begin
      if (tick) begin
        n.bcnt = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
      end else begin
        n.bcnt = s.bcnt - 16'h0001;
      end
    end
    // register writes
    if (wr) begin
      case (paddr_i)
        ulm_pkg::ULM_A_DATA: begin
          if (dlab) begin
            n.dll = pwdata_i[7:0];
          end else if (s.tx_cnt != CW'(DEPTH)) begin
            tx_push = 1'b1;
          end
        end
        ulm_pkg::ULM_A_IER: begin
          if (dlab) begin
            n.dlm = pwdata_i[7:0];
          end else begin
            n.ier = pwdata_i[7:0];
          end
        end
        ulm_pkg::ULM_A_FIFO: begin
          n.fifo_en = pwdata_i[ulm_pkg::ULM_FC_EN];
          if (pwdata_i[ulm_pkg::ULM_FC_EN]) begin
            rxrst = pwdata_i[ulm_pkg::ULM_FC_RXRST];
            txrst = pwdata_i[ulm_pkg::ULM_FC_TXRST];
            if (enh && pwdata_i[5:4] != 2'h0) begin
              n.trig = pwdata_i[5:4];
            end else begin
              n.trig = pwdata_i[7:6];
            end
          end
        end
        ulm_pkg::ULM_A_LCR: n.line_format_control = pwdata_i[7:0];
        ulm_pkg::ULM_A_MCR: n.modem_output_control = enh ? pwdata_i[7:0] : {s.modem_output_control[7:5], pwdata_i[4:0]};
        ulm_pkg::ULM_A_EFR: n.enhanced_feature_reg = pwdata_i[7:0];
        default: ;
      endcase
    end
    // transmitter
    if (tick) begin
      case (s.tx_st)
        ulm_pkg::ULM_IDLE: begin
          n.tx_line = 1'b1;
          if (s.tx_cnt != '0 && !s.halt) begin
            tx_pop = 1'b1;
            n.tx_sh = s.txf[s.tx_rp];
            n.tx_st = ulm_pkg::ULM_START;
            n.tx_tk = 6'h00;
            n.tx_line = 1'b0;
            n.tx_par = 1'b0;
          end
        end
        ulm_pkg::ULM_START, ulm_pkg::ULM_DATA, ulm_pkg::ULM_PAR, ulm_pkg::ULM_STOP: begin
          n.tx_tk = s.tx_tk + 6'h01;
          if (s.tx_tk == tx_last) begin
            n.tx_tk = 6'h00;
            case (s.tx_st)
              ulm_pkg::ULM_START: begin
                n.tx_st = ulm_pkg::ULM_DATA;
                n.tx_bit = 3'h0;
                n.tx_line = s.tx_sh[0];
              end
              ulm_pkg::ULM_DATA: begin
                n.tx_par = s.tx_par ^ s.tx_sh[0];
                n.tx_sh = {1'b0, s.tx_sh[7:1]};
                if (s.tx_bit == wl) begin
                  if (s.line_format_control[ulm_pkg::ULM_LCR_PEN]) begin
                    n.tx_st = ulm_pkg::ULM_PAR;
                    n.tx_line = par_bit(s.line_format_control, s.tx_par ^ s.tx_sh[0]);
                  end else begin
                    n.tx_st = ulm_pkg::ULM_STOP;
                    n.tx_line = 1'b1;
                  end
                end else begin
                  n.tx_bit = s.tx_bit + 3'h1;
                  n.tx_line = s.tx_sh[1];
                end
              end
              ulm_pkg::ULM_PAR: begin
                n.tx_st = ulm_pkg::ULM_STOP;
                n.tx_line = 1'b1;
              end
              default: n.tx_st = ulm_pkg::ULM_IDLE;
            endcase
          end
        end
        default: n.tx_st = ulm_pkg::ULM_IDLE;
      endcase
    end
    // receiver
    if (tick) begin
      case (s.rx_st)
        ulm_pkg::ULM_IDLE: begin
          if (!rx_in) begin
            n.rx_st = ulm_pkg::ULM_START;
            n.rx_tk = 6'h00;
          end
        end
        ulm_pkg::ULM_START: begin
          n.rx_tk = s.rx_tk + 6'h01;
          if (s.rx_tk == 6'(OSR / 2 - 1)) begin
            n.rx_tk = 6'h00;
            n.rx_bit = 3'h0;
            n.rx_par = 1'b0;
            n.rx_pe = 1'b0;
            n.rx_st = rx_in ? ulm_pkg::ULM_IDLE : ulm_pkg::ULM_DATA;
          end
        end
        ulm_pkg::ULM_DATA, ulm_pkg::ULM_PAR, ulm_pkg::ULM_STOP: begin
          n.rx_tk = s.rx_tk + 6'h01;
          if (s.rx_tk == 6'(OSR - 1)) begin
            n.rx_tk = 6'h00;
            case (s.rx_st)
              ulm_pkg::ULM_DATA: begin
                n.rx_sh = {rx_in, s.rx_sh[7:1]};
                n.rx_par = s.rx_par ^ rx_in;
                n.rx_bit = s.rx_bit + 3'h1;
                if (s.rx_bit == wl) begin
                  n.rx_st = s.line_format_control[ulm_pkg::ULM_LCR_PEN] ? ulm_pkg::ULM_PAR : ulm_pkg::ULM_STOP;
                end
              end
              ulm_pkg::ULM_PAR: begin
                n.rx_pe = (rx_in != par_bit(s.line_format_control, s.rx_par));
                n.rx_st = ulm_pkg::ULM_STOP;
              end
              default: begin
                n.rx_st = ulm_pkg::ULM_IDLE;
                char_done = 1'b1;
              end
            endcase
          end
        end
        default: n.rx_st = ulm_pkg::ULM_IDLE;
      endcase
    end
    // completed character
    if (char_done) begin
      if (enh && s.modem_output_control[ulm_pkg::ULM_MCR_XANY]) begin
        n.halt = 1'b0;
      end
      if (swfc && rx_char == ulm_pkg::ULM_XOFF) begin
        n.halt = 1'b1;
      end else if (swfc && rx_char == ulm_pkg::ULM_XON) begin
        n.halt = 1'b0;
      end else if (s.rx_cnt == CW'(DEPTH)) begin
        ovr_set = 1'b1;
      end else begin
        rx_push = 1'b1;
      end
    end
    // reads with side effects
    if (rd && paddr_i == ulm_pkg::ULM_A_DATA && !dlab && dr) begin
      rx_pop = 1'b1;
    end
    if (rd && paddr_i == ulm_pkg::ULM_A_LSR) begin
      lsr_rd = 1'b1;
    end
    n.ovr = ovr_set | (s.ovr & ~lsr_rd);
    // fifo pointers
    if (tx_push) begin
      n.txf[s.tx_wp] = pwdata_i[7:0];
      n.tx_wp = s.tx_wp + AW'(1);
    end
    if (tx_pop) begin
      n.tx_rp = s.tx_rp + AW'(1);
    end
    n.tx_cnt = s.tx_cnt + CW'(tx_push) - CW'(tx_pop);
    if (rx_push) begin
      n.rxf[s.rx_wp] = {s.rx_pe, rx_char};
      n.rx_wp = s.rx_wp + AW'(1);
    end
    if (rx_pop) begin
      n.rx_rp = s.rx_rp + AW'(1);
    end
    n.rx_cnt = s.rx_cnt + CW'(rx_push) - CW'(rx_pop);
    if (txrst) begin
      n.tx_wp = '0;
      n.tx_rp = '0;
      n.tx_cnt = '0;
    end
    if (rxrst) begin
      n.rx_wp = '0;
      n.rx_rp = '0;
      n.rx_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s <= '0;
      s.tx_line <= 1'b1;
      s.s1 <= 1'b1;
      s.s2 <= 1'b1;
      s.s3 <= 1'b1;
      s.rxd <= 1'b1;
    end else if (ce_i) begin
      s <= n;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  // trigger level rebuilt from the table for the interrupt checks
  logic [CW-1:0] exp_lvl;
  assign exp_lvl = (s.trig == 2'h0) ? CW'(ulm_pkg::ULM_TRIG0) : (s.trig == 2'h1) ? CW'(ulm_pkg::ULM_TRIG1) :
                   (s.trig == 2'h2) ? CW'(ulm_pkg::ULM_TRIG2) : CW'(ulm_pkg::ULM_TRIG3);

  property p_trig_rx;
    (wr && paddr_i == ulm_pkg::ULM_A_FIFO && pwdata_i[0] && !enh) |=> (s.trig == $past(pwdata_i[7:6]));
  endproperty
  a_trig_rx: assert property (p_trig_rx) else $error("receive trigger not taken");
  property p_trig_tx;
    (wr && paddr_i == ulm_pkg::ULM_A_FIFO && pwdata_i[0] && enh && pwdata_i[5:4] != 2'h0)
      |=> (s.trig == $past(pwdata_i[5:4]));
  endproperty
  a_trig_tx: assert property (p_trig_tx) else $error("transmit trigger not taken");
  property p_rx_int;
    (s.ier[ulm_pkg::ULM_IER_RX] && s.rx_cnt >= exp_lvl) |-> int_o;
  endproperty
  a_rx_int: assert property (p_rx_int) else $error("receive interrupt missing");
  property p_tx_int;
    (s.ier[ulm_pkg::ULM_IER_TX] && s.tx_cnt < exp_lvl) |-> int_o;
  endproperty
  a_tx_int: assert property (p_tx_int) else $error("transmit interrupt missing");
  property p_brk;
    (brk && !loop) ##1 (brk && !loop) |-> !tx_o && !$past(tx_o);
  endproperty
  a_brk: assert property (p_brk) else $error("break not held low");
  property p_ovr;
    (ce_i && ovr_set && !rx_pop) |=> (s.ovr && s.rx_cnt == $past(s.rx_cnt));
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun handling wrong");
  property p_dr;
    (ce_i && rx_push) |=> line_status[0];
  endproperty
  a_dr: assert property (p_dr) else $error("data ready not set");
  property p_ls_int;
    (ce_i && ovr_set && s.ier[ulm_pkg::ULM_IER_LS]) |=> int_o;
  endproperty
  a_ls_int: assert property (p_ls_int) else $error("overrun interrupt missing");
  property p_dtr;
    (ce_i && wr && paddr_i == ulm_pkg::ULM_A_MCR && !pwdata_i[ulm_pkg::ULM_MCR_LOOP])
      |=> (dtr_n_o == !$past(pwdata_i[ulm_pkg::ULM_MCR_DTR]));
  endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready level wrong");
  property p_rts;
    (ce_i && wr && paddr_i == ulm_pkg::ULM_A_MCR && !pwdata_i[4]) |=> (rts_n_o == !$past(pwdata_i[1]));
  endproperty
  a_rts: assert property (p_rts) else $error("request to send level wrong");
  property p_ir_idle;
    (ir && !loop && !brk && s.tx_st == ulm_pkg::ULM_IDLE) |-> !tx_o;
  endproperty
  a_ir_idle: assert property (p_ir_idle) else $error("infrared idle not low");
  property p_pre;
    (tick && s.modem_output_control[7]) |-> (s.pre == 2'h3);
  endproperty
  a_pre: assert property (p_pre) else $error("prescaler tick misplaced");
  property p_xany;
    (ce_i && char_done && enh && s.modem_output_control[5] && !swfc) |=> !s.halt;
  endproperty
  a_xany: assert property (p_xany) else $error("xon-any did not resume");
  c_rx_push: cover property (ce_i && rx_push);
  c_ovr: cover property (ce_i && ovr_set);
  c_tx_pop: cover property (ce_i && tx_pop ##1 s.tx_st == ulm_pkg::ULM_START);
endmodule

// File: verification/ulm_remote.sv
`timescale 1ns/1ps
module ulm_remote #(
  parameter int OSR = 4
) (
  // clock
  input wire logic clk_i,
  // serial line
  input wire logic tx_i,
  output logic rx_o
);
  logic [11:0] frame;
  int nfr;
  initial begin
    rx_o = 1'b1;
    frame = '0;
    nfr = 0;
  end
  // capture bits after a start edge, mid-bit
  always begin
    @(negedge tx_i);
    repeat (OSR / 2) @(posedge clk_i);
    for (int i = 0; i < 12; i++) begin
      repeat (OSR) @(posedge clk_i);
      frame[i] = tx_i;
    end
    nfr++;
  end
  // start bit, then bits lsb first, line back to mark
  task automatic send(input logic [11:0] bits);
    @(posedge clk_i);
    rx_o <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      repeat (OSR) @(posedge clk_i);
      rx_o <= bits[i];
    end
    repeat (OSR) @(posedge clk_i);
  endtask
endmodule

// File: verification/test_uart_line_modem_control.sv
`timescale 1ns/1ps
module test_uart_line_modem_control;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic err;
  logic rx;
  logic tx;
  logic dtr_n;
  logic rts_n;
  logic int_o;
  logic int_oe;
  int n_fail = 0;
  int checked = 0;
  always #5 clk = ~clk;
  ulm_uart #(.OSR(4)) u_dut (.clk_sys_i(clk), .srst_i(srst), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rx_i(rx), .tx_o(tx), .dtr_n_o(dtr_n), .rts_n_o(rts_n), .int_o(int_o),
    .int_oe_o(int_oe));
  ulm_remote #(.OSR(4)) u_rem (.clk_i(clk), .tx_i(tx), .rx_o(rx));
  task automatic end_sim();
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, x);
  endtask
  // frame bits after start: data lsb first, parity, then mark
  function automatic logic [11:0] frm(input logic [7:0] d, input logic [7:0] l);
    logic [7:0] m;
    frm = 12'hfff;
    m = d & (8'hff >> (2'd3 - l[1:0]));
    for (int i = 0; i < 5 + l[1:0]; i++) frm[i] = d[i];
    if (l[3]) frm[5 + l[1:0]] = l[5] ? ~l[4] : (^m) ^ ~l[4];
  endfunction
  task automatic rst();
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
  task automatic t_reset();
    rd(ulm_pkg::ULM_A_LCR, 8'h00);
    rd(ulm_pkg::ULM_A_MCR, 8'h00);
    rd(ulm_pkg::ULM_A_LSR, 8'h60);
    chk({tx, dtr_n, rts_n, int_o, int_oe}, 5'h1c);
    rd(8'h20, 8'h00);
    chk(err, 1'b1);
  endtask
  task automatic t_modem();
    wr(ulm_pkg::ULM_A_MCR, 8'h01);
    chk({dtr_n, rts_n}, 2'h1);
    wr(ulm_pkg::ULM_A_MCR, 8'h02);
    chk({dtr_n, rts_n}, 2'h2);
    wr(ulm_pkg::ULM_A_MCR, 8'h08);
    chk(int_oe, 1'b1);
    wr(ulm_pkg::ULM_A_MCR, 8'h1f);
    rd(ulm_pkg::ULM_A_LOOP, 8'h01);
    wr(ulm_pkg::ULM_A_MCR, 8'h10);
    rd(ulm_pkg::ULM_A_LOOP, 8'h02);
    wr(ulm_pkg::ULM_A_LCR, 8'h03);
    wr(ulm_pkg::ULM_A_DATA, 8'h55);
    repeat (80) @(posedge clk);
    chk(tx, 1'b1);
    rd(ulm_pkg::ULM_A_DATA, 8'h55);
  endtask
  task automatic t_format();
    logic [7:0] tab [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0b, 8'h1b, 8'h2b, 8'h3e};
    int c;
    for (int j = 0; j < 8; j++) begin
      c = u_rem.nfr;
      wr(ulm_pkg::ULM_A_LCR, tab[j]);
      wr(ulm_pkg::ULM_A_DATA, 8'ha7);
      for (int k = 0; k < 300 && u_rem.nfr == c; k++) @(posedge clk);
      chk(u_rem.frame, frm(8'ha7, tab[j]));
    end
  endtask
  task automatic t_break();
    wr(ulm_pkg::ULM_A_LCR, 8'h43);
    repeat (40) @(posedge clk);
    chk(tx, 1'b0);
    wr(ulm_pkg::ULM_A_LCR, 8'h03);
    repeat (2) @(posedge clk);
    chk(tx, 1'b1);
  endtask
  task automatic t_rx();
    logic [7:0] tab [4] = '{8'h0b, 8'h1b, 8'h2b, 8'h3b};
    for (int j = 0; j < 4; j++) begin
      wr(ulm_pkg::ULM_A_LCR, tab[j]);
      for (int b = 0; b < 2; b++) begin
        u_rem.send(frm(8'h5a, tab[j]) ^ (b ? 12'h100 : 12'h000));
        rd(ulm_pkg::ULM_A_LSR, b ? 8'h65 : 8'h61);
        rd(ulm_pkg::ULM_A_DATA, 8'h5a);
        rd(ulm_pkg::ULM_A_LSR, 8'h60);
      end
    end
    wr(ulm_pkg::ULM_A_LCR, 8'h03);
    wr(ulm_pkg::ULM_A_IER, 8'h04);
    for (int i = 0; i < 17; i++) u_rem.send(frm(i[7:0], 8'h03));
    chk(int_o, 1'b1);
    rd(ulm_pkg::ULM_A_LSR, 8'h63);
    rd(ulm_pkg::ULM_A_DATA, 8'h00);
    rd(ulm_pkg::ULM_A_LSR, 8'h61);
  endtask
  task automatic t_trig();
    wr(ulm_pkg::ULM_A_MCR, 8'h08);
    wr(ulm_pkg::ULM_A_IER, 8'h01);
    wr(ulm_pkg::ULM_A_LCR, 8'h03);
    wr(ulm_pkg::ULM_A_FIFO, 8'h41);
    for (int i = 0; i < 3; i++) u_rem.send(frm(8'h30, 8'h03));
    chk(int_o, 1'b0);
    u_rem.send(frm(8'h31, 8'h03));
    chk(int_o, 1'b1);
    rd(ulm_pkg::ULM_A_FIFO, 8'hc4);
    wr(ulm_pkg::ULM_A_FIFO, 8'hc1);
    @(posedge clk);
    chk(int_o, 1'b0);
    wr(ulm_pkg::ULM_A_FIFO, 8'h40);
    @(posedge clk);
    chk(int_o, 1'b0);
    rd(ulm_pkg::ULM_A_FIFO, 8'h01);
    wr(ulm_pkg::ULM_A_EFR, 8'h10);
    wr(ulm_pkg::ULM_A_FIFO, 8'h11);
    @(posedge clk);
    chk(int_o, 1'b1);
  endtask
  task automatic t_dlab();
    wr(ulm_pkg::ULM_A_LCR, 8'h80);
    wr(ulm_pkg::ULM_A_DATA, 8'h37);
    rd(ulm_pkg::ULM_A_DATA, 8'h37);
    wr(ulm_pkg::ULM_A_LCR, 8'h00);
    rd(ulm_pkg::ULM_A_LSR, 8'h60);
  endtask
  task automatic t_pre();
    wr(ulm_pkg::ULM_A_EFR, 8'h10);
    wr(ulm_pkg::ULM_A_MCR, 8'hb0);
    wr(ulm_pkg::ULM_A_LCR, 8'h03);
    wr(ulm_pkg::ULM_A_DATA, 8'h55);
    repeat (100) @(posedge clk);
    rd(ulm_pkg::ULM_A_LSR, 8'h20);
    repeat (200) @(posedge clk);
    rd(ulm_pkg::ULM_A_LSR, 8'h61);
    rd(ulm_pkg::ULM_A_DATA, 8'h55);
  endtask
  task automatic t_ir();
    int k;
    wr(ulm_pkg::ULM_A_EFR, 8'h10);
    wr(ulm_pkg::ULM_A_MCR, 8'h40);
    chk(tx, 1'b0);
    wr(ulm_pkg::ULM_A_DATA, 8'hff);
    for (k = 0; k < 40 && tx !== 1'b1; k++) @(posedge clk);
    chk(tx, 1'b1);
    repeat (4) @(posedge clk);
    chk(tx, 1'b0);
  endtask
  task automatic t_ce();
    @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    chk(pready, 1'b0);
    ce <= 1'b1;
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  initial begin
    rst();
    t_reset();
    rst();
    t_modem();
    rst();
    t_format();
    rst();
    t_break();
    rst();
    t_rx();
    rst();
    t_trig();
    rst();
    t_dlab();
    rst();
    t_pre();
    rst();
    t_ir();
    rst();
    t_ce();
    end_sim();
  end
endmodule
